// >>> hdl/paso_core.sv
// converter digital side: sample capture, stage pipe, correction, output
`timescale 1ns/1ps
`default_nettype none
`include "paso_consts.svh"
//
// Contract
// - word leaves on an 8-bit bus, msb on the highest line
// - sampling switches closed and tracking while the sample clock is high
// - each falling sample clock edge captures one sample and starts its conversion
// - eight stages each resolve one bit and pass the doubled residue on
// - stage decisions merged by error correction before forming the word
// - word appears five sample clocks after its falling edge
// - at or above positive full scale: flag high, all data bits high
// - below negative full scale: flag high, all data bits low
// - in-range conversion keeps the flag low
// - power_down_n low means shutdown; high for normal conversion
// - straight binary: all ones at +1 V, all zeros at -1 V
//
module paso_core
    import paso_pkg::*;
#(
    parameter int WORD_W  = `PASO_WORD_W,
    parameter int LATENCY = `PASO_LATENCY
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              sample_clk_in,
    input  wire logic              power_down_n_in,
    input  wire logic signed [9:0] analog_in,
    output logic                   track_out,
    output logic [WORD_W-1:0]      sample_word_bits_out,
    output logic                   range_fault_flag_out,
    output logic                   word_strobe_out
);
    // ****************************************
    // state
    // ****************************************
    // analog_in: signed residue scale, +-256 is +-1 V full scale
    typedef struct packed {
        logic                   clk_d;
        logic                   track;
        paso_mode_t             mode;
        logic [4:0][10:0]       held;
        logic [4:0][7:0]        raw;
        logic [4:0]             vld;
        logic [WORD_W-1:0]      word;
        logic                   fault;
        logic                   strobe;
        // falls since wake, saturating; lets the latency check count apart from the shift chain
        logic [2:0]             falls_seen;
    } paso_st_t;
    paso_st_t s;
    paso_st_t next_s;
    paso_fifo_if #(.W(WORD_W + 1)) q ();
    paso_fifo #(.W(WORD_W + 1), .DEPTH(`PASO_FIFO_DEPTH)) u_fifo (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .f        (q)
    );
    logic fall;
    assign fall = s.clk_d && !sample_clk_in;
    // ****************************************
    // stage model and correction
    // ****************************************
    // redundant 1.5-bit decisions let a small comparator error be absorbed
    function automatic logic [7:0] paso_convert(input logic signed [10:0] v);
        logic signed [11:0] r;
        logic signed [10:0] acc;
        r   = {v[10], v};
        acc = '0;
        for (int i = 0; i < `PASO_STAGES; i++)
        begin
            acc = acc <<< 1;
            if (r >= 12'sd64)
            begin
                acc = acc + 11'sd1;
                r   = (r - 12'sd128) <<< 1;
            end
            else if (r < -12'sd64)
            begin
                acc = acc - 11'sd1;
                r   = (r + 12'sd128) <<< 1;
            end
            else
                r = r <<< 1;
        end
        acc = (acc + 11'sd256) >>> 1; // offset binary, halved onto the 8-bit span
        if (acc > 11'sd255)
            acc = 11'sd255;
        else if (acc < 11'sd0)
            acc = 11'sd0;
        return acc[7:0];
    endfunction
    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_s        = s;
        next_s.clk_d  = sample_clk_in;
        next_s.strobe = 1'b0;
        next_s.mode   = power_down_n_in ? PASO_RUN : PASO_DOWN;
        next_s.track  = power_down_n_in && sample_clk_in;
        if (!power_down_n_in)
        begin
            next_s.vld        = '0; // shutdown drops the samples in flight
            next_s.falls_seen = '0;
        end
        else if (fall)
        begin
            if (s.falls_seen != 3'(LATENCY))
                next_s.falls_seen = s.falls_seen + 3'h1;
            for (int k = 4; k > 0; k--)
            begin
                next_s.held[k] = s.held[k-1];
                next_s.raw[k]  = s.raw[k-1];
                next_s.vld[k]  = s.vld[k-1];
            end
            next_s.held[0] = {analog_in[9], analog_in};
            next_s.raw[0]  = paso_convert({analog_in[9], analog_in});
            next_s.vld[0]  = 1'b1;
        end
        if (q.rvalid)
        begin
            {next_s.fault, next_s.word} = q.rdata;
            next_s.strobe = 1'b1;
        end
    end
    // fifth edge after capture pushes the finished word; buffer never fills at one word per edge
    assign q.wvalid = fall && power_down_n_in && s.vld[LATENCY-1];
    assign q.rready = 1'b1;
    always_comb
    begin
        logic signed [10:0] h;
        h = s.held[LATENCY-1];
        if (h >= 11'sd256)
            q.wdata = {1'b1, `PASO_CODE_MAX};
        else if (h < -11'sd256)
            q.wdata = {1'b1, `PASO_CODE_MIN};
        else
            q.wdata = {1'b0, s.raw[LATENCY-1]};
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end
    assign track_out            = s.track;
    assign sample_word_bits_out = s.word;
    assign range_fault_flag_out = s.fault;
    assign word_strobe_out      = s.strobe;
    // ****************************************
    // checks
    // ****************************************
    sequence s_fall;
        $fell(sample_clk_in) && power_down_n_in;
    endsequence
    property p_track;
        @(posedge mclk_in) disable iff (!rst_n_in) ##1 track_out == $past(sample_clk_in && power_down_n_in);
    endproperty
    a_track: assert property (p_track) else $error("track level wrong");
    property p_over;
        @(posedge mclk_in) disable iff (!rst_n_in)
            range_fault_flag_out && sample_word_bits_out != 8'h00 |-> sample_word_bits_out == 8'hff;
    endproperty
    a_over: assert property (p_over) else $error("overrange code wrong");
    property p_under;
        @(posedge mclk_in) disable iff (!rst_n_in)
            range_fault_flag_out && sample_word_bits_out != 8'hff |-> sample_word_bits_out == 8'h00;
    endproperty
    a_under: assert property (p_under) else $error("underrange code wrong");
    property p_inrange;
        @(posedge mclk_in) disable iff (!rst_n_in)
            q.wvalid && $signed(s.held[4]) < 11'sd256 && $signed(s.held[4]) >= -11'sd256 |-> !q.wdata[8];
    endproperty
    a_inrange: assert property (p_inrange) else $error("flag set in range");
    property p_down;
        @(posedge mclk_in) disable iff (!rst_n_in)
            !power_down_n_in |=> s.vld == '0 && !track_out && s.mode == PASO_DOWN;
    endproperty
    a_down: assert property (p_down) else $error("shutdown ignored");
    property p_latency;
        @(posedge mclk_in) disable iff (!rst_n_in) q.wvalid |-> fall && s.falls_seen == 3'(LATENCY);
    endproperty
    a_latency: assert property (p_latency) else $error("word pushed off its edge");
    property p_push;
        @(posedge mclk_in) disable iff (!rst_n_in) s_fall ##0 (s.falls_seen == 3'(LATENCY)) |-> q.wvalid;
    endproperty
    a_push: assert property (p_push) else $error("due word not pushed");
    // no backpressure path: a full buffer would lose a word silently
    property p_room;
        @(posedge mclk_in) disable iff (!rst_n_in) q.wvalid |-> q.wready;
    endproperty
    a_room: assert property (p_room) else $error("buffer full on push");
    property p_strobe;
        @(posedge mclk_in) disable iff (!rst_n_in) q.wvalid |-> ##[2:3] word_strobe_out;
    endproperty
    a_strobe: assert property (p_strobe) else $error("word not shown");
    property p_capture;
        @(posedge mclk_in) disable iff (!rst_n_in) s_fall |=> s.vld[0] && s.held[0] == $past({analog_in[9], analog_in});
    endproperty
    a_capture: assert property (p_capture) else $error("sample not captured");
endmodule
`default_nettype wire

// >>> hdl/paso_fifo.sv
// buffer of finished words between the stage pipe and the output pins
`timescale 1ns/1ps
`default_nettype none
module paso_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    paso_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0]  wp;
        logic [AW:0]  rp;
        logic [W-1:0] rdata;
        logic         rvalid;
    } paso_fq_t;
    paso_fq_t     s;
    paso_fq_t     next_s;
    logic [W-1:0] mem [DEPTH];
    logic         full;
    logic         empty;
    logic         pop;
    assign full    = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
    assign empty   = (s.wp == s.rp);
    assign f.wready = !full;
    assign f.rdata  = s.rdata;
    assign f.rvalid = s.rvalid;
    // read data leaves from a register, one word staged ahead
    assign pop = !empty && (!s.rvalid || f.rready);
    always_comb
    begin
        next_s = s;
        if (f.wvalid && !full)
            next_s.wp = s.wp + 1'b1;
        if (pop)
        begin
            next_s.rdata  = mem[s.rp[AW-1:0]];
            next_s.rvalid = 1'b1;
            next_s.rp     = s.rp + 1'b1;
        end
        else if (f.rready)
            next_s.rvalid = 1'b0;
    end
    always_ff @(posedge mclk_in)
    begin
        if (f.wvalid && !full)
            mem[s.wp[AW-1:0]] <= f.wdata;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end
endmodule
`default_nettype wire

// >>> inc/paso_consts.svh
// constants for the pipelined sample output block
`ifndef PASO_CONSTS_SVH
`define PASO_CONSTS_SVH
`define PASO_WORD_W        8
`define PASO_STAGES        8
`define PASO_LATENCY       5
`define PASO_FIFO_DEPTH    16
`define PASO_CODE_MAX      8'hff
`define PASO_CODE_MIN      8'h00
`define PASO_MIN_CLK_NS    50
`define PASO_MCLK_NS       25
`define PASO_MIN_CLK_CYC   ((`PASO_MIN_CLK_NS + `PASO_MCLK_NS - 1) / `PASO_MCLK_NS)
`endif

// >>> inc/paso_fifo_if.sv
// carrier between the converter core and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface paso_fifo_if #(parameter int W = 9);
    logic [W-1:0] wdata;
    logic         wvalid;
    logic         wready;
    logic [W-1:0] rdata;
    logic         rvalid;
    logic         rready;
    modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
    modport core (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready);
endinterface
`default_nettype wire

// >>> inc/paso_pkg.sv
// types of the pipelined sample output block
package paso_pkg;
    typedef enum logic [1:0] {PASO_RUN, PASO_DOWN} paso_mode_t;
    typedef struct packed {
        logic [7:0] code;
        logic       fault;
    } paso_word_t;
endpackage

// >>> verif/paso_capture_model.sv
// capture side model: makes the sample clock and latches words
`timescale 1ns/1ps
`default_nettype none
module paso_capture_model #(
    parameter int HALF = 2
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       run_in,
    output logic            sample_clk_out,
    input  wire logic       strobe_in,
    input  wire logic [7:0] word_in,
    input  wire logic       flag_in,
    output logic [8:0]      latched_out,
    output logic            got_out
);
    int cnt;
    // clock stands low outside runs; 4 mclk period keeps it at 10 MHz
    always @(negedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in || !run_in)
        begin
            sample_clk_out <= 1'b0;
            cnt            <= 0;
        end
        else if (cnt == HALF - 1)
        begin
            sample_clk_out <= ~sample_clk_out;
            cnt            <= 0;
        end
        else
            cnt <= cnt + 1;
    end
    // word and flag taken as one unit on the strobe
    always @(posedge mclk_in)
    begin
        got_out <= strobe_in;
        if (strobe_in)
            latched_out <= {flag_in, word_in};
    end
endmodule
`default_nettype wire

// >>> verif/test_pipelined_adc_sample_output.sv
// self-checking bench of the converter digital side
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module test_pipelined_adc_sample_output;
    logic              mclk_in = 1'b0;
    logic              rst_n_in = 1'b0;
    logic              power_down_n_in = 1'b0;
    logic              run = 1'b0;
    logic signed [9:0] analog_in = 10'sh000;
    logic              sample_clk, track, strobe, flag, got;
    logic [7:0]        word;
    logic [8:0]        latched;
    int                failures = 0;
    int                checks_done = 0;
    int                falls = 0;
    int                ignore = 0;
    logic              prev_sc = 1'b0, prev_pd = 1'b0, prev_rst = 1'b0;
    int                q_v[$];
    int                q_f[$];
    int                corner[9] = '{255, -256, 256, 511, -257, -512, 0, -1, 1};

    always #12.5 mclk_in = ~mclk_in;

    paso_core u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sample_clk_in(sample_clk),
        .power_down_n_in(power_down_n_in), .analog_in(analog_in), .track_out(track),
        .sample_word_bits_out(word), .range_fault_flag_out(flag), .word_strobe_out(strobe));
    paso_capture_model u_cap (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .run_in(run),
        .sample_clk_out(sample_clk), .strobe_in(strobe), .word_in(word), .flag_in(flag),
        .latched_out(latched), .got_out(got));

    // nearest straight-binary code, roughly v/2 + 128
    function automatic int exp_code(input int v);
        int e;
        e = (v + 256) / 2;
        return (e > 255) ? 255 : e;
    endfunction

    task automatic check_word();
        int v, f, e;
        if (q_v.size() == 0)
        begin
            `CHECK(1'b0, 1'b1)
            return;
        end
        v = q_v.pop_front();
        f = q_f.pop_front();
        `CHECK(falls - f, 5)
        `CHECK(latched[8], (v >= 256 || v < -256))
        if (v >= 256)
            `CHECK(latched[7:0], 8'hff)
        else if (v < -256)
            `CHECK(latched[7:0], 8'h00)
        else
        begin
            e = exp_code(v);
            `CHECK(int'(latched[7:0]) + 1 >= e && int'(latched[7:0]) <= e + 1, 1'b1)
        end
    endtask

    // word check before fall count: a fall may land on the same edge
    always @(posedge mclk_in)
    begin
        if (rst_n_in && prev_rst)
            `CHECK(track, prev_sc & prev_pd)
        if (got && ignore == 0)
            check_word();
        if (prev_sc && !sample_clk && power_down_n_in && rst_n_in)
        begin
            falls++;
            q_v.push_back(int'(analog_in));
            q_f.push_back(falls);
        end
        if (!power_down_n_in)
        begin
            q_v.delete();
            q_f.delete();
            ignore = 4;
        end
        else if (ignore > 0)
            ignore--;
        prev_sc = sample_clk;
        prev_pd = power_down_n_in;
        prev_rst = rst_n_in;
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard: run needs about 20 us
    initial
    begin
        #60000;
        failures++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(55));
        repeat (5) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        power_down_n_in = 1'b1;
        run = 1'b1;
        for (int i = 0; i < 800; i++)
        begin
            @(negedge mclk_in);
            // corners held four cycles so a fall sees each one
            if (i / 4 < 9)
                analog_in = 10'(corner[i / 4]);
            else
                analog_in = 10'(int'($urandom_range(0, 640)) - 320);
            if (i == 400)
                power_down_n_in = 1'b0;
            if (i == 480)
                power_down_n_in = 1'b1;
        end
        run = 1'b0;
        repeat (20) @(negedge mclk_in);
        print_verdict();
    end
endmodule
`default_nettype wire
